//--- hw/panel_map_map.vh
// Mode codes, pixel word layout and buffer sizing for the panel data mapper.
`ifndef PANEL_MAP_MAP_VH
`define PANEL_MAP_MAP_VH

// ----------------------------------------------------------------------------
// Panel format selection codes
// ----------------------------------------------------------------------------
`define MODE_W 3
`define MODE_TFT24 3'h0
`define MODE_TFT18 3'h1
`define MODE_TFT12 3'h2
`define MODE_TFT9 3'h3
`define MODE_STN16 3'h4
`define MODE_STN8 3'h5
`define MODE_MONO 3'h6

// ----------------------------------------------------------------------------
// Pixel word layout
// ----------------------------------------------------------------------------
`define WORD_W 24
`define RED_MSB 23
`define RED_LSB 16
`define GREEN_MSB 15
`define GREEN_LSB 8
`define BLUE_MSB 7
`define BLUE_LSB 0
`define LOWER_MSB 7
`define LOWER_LSB 0
`define UPPER_MSB 15
`define UPPER_LSB 8

// ----------------------------------------------------------------------------
// Buffer entry layout and sizing
// ----------------------------------------------------------------------------
`define ENTRY_W 26
`define ENTRY_LINE_BIT 24
`define ENTRY_FRAME_BIT 25
`define BUF_DEPTH 2
`define BUF_CNT_W 2
`define BUF_FULL 2'h2

`endif

//--- hw/lcd_panel_data_mapper.v
// Pixel stream to flat-panel data line mapper with shift, line and frame strobes.
`timescale 1ns/10ps
`include "panel_map_map.vh"

module lcd_panel_data_mapper (
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  input wire [`MODE_W-1:0] panel_mode,
  input wire pix_clk,
  input wire in_valid,
  output wire in_ready,
  input wire [`WORD_W-1:0] in_word,
  input wire in_line_end,
  input wire in_frame_first,
  output wire [`WORD_W-1:0] panel_data_out,
  output wire panel_shift_clock,
  output wire panel_line_clock,
  output wire frame_start_pulse
);

  // --------------------------------------------------------------------------
  // Output state machine codes
  // --------------------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_SHOW = 2'b10;

  // --------------------------------------------------------------------------
  // Mapping of one pixel word onto the panel data lines
  // --------------------------------------------------------------------------
  function [`WORD_W-1:0] map_word;
    input [`MODE_W-1:0] mode;
    input [`WORD_W-1:0] w;
    reg [7:0] red;
    reg [7:0] grn;
    reg [7:0] blu;
    reg [7:0] stn_color_lower_bits;
    reg [7:0] stn_color_upper_bits;
    reg [3:0] mono_lower_half_bits;
    reg [3:0] mono_upper_half_bits;
    reg [`WORD_W-1:0] o;
    begin
      red = w[`RED_MSB:`RED_LSB];
      grn = w[`GREEN_MSB:`GREEN_LSB];
      blu = w[`BLUE_MSB:`BLUE_LSB];
      stn_color_lower_bits = w[`LOWER_MSB:`LOWER_LSB];
      stn_color_upper_bits = w[`UPPER_MSB:`UPPER_LSB];
      mono_lower_half_bits = w[3:0];
      mono_upper_half_bits = w[11:8];
      // Every line starts low so that lines a format leaves unused stay low.
      o = 24'h000000;
      case (mode)
        `MODE_TFT24: begin
          o[7:0] = blu;
          o[15:8] = grn;
          o[21:16] = red[5:0];
          o[23:22] = red[7:6];
        end
        `MODE_TFT18: begin
          // Narrow panels take the most significant bits of each colour.
          o[7:2] = blu[7:2];
          o[15:10] = grn[7:2];
          o[21:18] = red[5:2];
          o[23:22] = red[7:6];
        end
        `MODE_TFT12: begin
          o[7:4] = blu[7:4];
          o[15:12] = grn[7:4];
          o[21:20] = red[5:4];
          o[23:22] = red[7:6];
        end
        `MODE_TFT9: begin
          o[7:5] = blu[7:5];
          o[13] = grn[5];
          o[14] = grn[6];
          o[15] = grn[7];
          o[21] = red[5];
          o[23:22] = red[7:6];
        end
        `MODE_STN16: begin
          o[7:4] = stn_color_lower_bits[3:0];
          o[13:12] = stn_color_lower_bits[5:4];
          o[15:14] = stn_color_lower_bits[7:6];
          o[11:10] = stn_color_upper_bits[5:4];
          o[19:18] = stn_color_upper_bits[7:6];
          o[21:20] = stn_color_upper_bits[1:0];
          o[23:22] = stn_color_upper_bits[3:2];
        end
        `MODE_STN8: begin
          o[7:4] = stn_color_lower_bits[3:0];
          o[13:12] = stn_color_upper_bits[1:0];
          o[15:14] = stn_color_upper_bits[3:2];
        end
        `MODE_MONO: begin
          o[7:4] = mono_lower_half_bits;
          o[13:12] = mono_upper_half_bits[1:0];
          o[15:14] = mono_upper_half_bits[3:2];
        end
        default: begin
          o = 24'h000000;
        end
      endcase
      map_word = o;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  wire rst_n = rst_sync_q;

  // --------------------------------------------------------------------------
  // Pixel clock sampling and edge detection
  // --------------------------------------------------------------------------
  reg pclk_meta_q;
  reg pclk_sync_q;
  reg pclk_prev_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_meta_q <= 1'b0;
      pclk_sync_q <= 1'b0;
      pclk_prev_q <= 1'b0;
    end else if (clk_en) begin
      pclk_meta_q <= pix_clk;
      pclk_sync_q <= pclk_meta_q;
      pclk_prev_q <= pclk_sync_q;
    end
  end

  wire pclk_rise = pclk_sync_q & ~pclk_prev_q;
  wire pclk_fall = ~pclk_sync_q & pclk_prev_q;

  // --------------------------------------------------------------------------
  // Panel format selection register
  // --------------------------------------------------------------------------
  reg [`MODE_W-1:0] mode_q;

  // The mode is held with each frame so a change never tears a frame.
  reg mode_seen_q;

  // --------------------------------------------------------------------------
  // Two-entry word buffer
  // --------------------------------------------------------------------------
  reg [`ENTRY_W-1:0] buf_mem [0:`BUF_DEPTH-1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [`BUF_CNT_W-1:0] count_q;
  reg [`BUF_CNT_W-1:0] count_d;
  reg in_ready_q;
  reg [1:0] state_q;
  reg [1:0] state_d;

  wire push = in_valid & in_ready_q;
  wire buf_has = (count_q != 2'h0);
  wire pop = pclk_rise & buf_has;
  wire [`ENTRY_W-1:0] head = buf_mem[rd_ptr_q];

  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 2'h1;
    end else if (pop && !push) begin
      count_d = count_q - 2'h1;
    end
  end

  always @(posedge clk) begin
    if (clk_en && push) begin
      buf_mem[wr_ptr_q] <= {in_frame_first, in_line_end, in_word};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      in_ready_q <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_d;
      in_ready_q <= (count_d != `BUF_FULL);
    end
  end

  assign in_ready = in_ready_q;

  // --------------------------------------------------------------------------
  // Panel output sequencing
  // --------------------------------------------------------------------------
  reg [`WORD_W-1:0] data_q;
  reg shift_q;
  reg line_q;
  reg frame_q;

  wire [`MODE_W-1:0] mode_use = head[`ENTRY_FRAME_BIT] ? panel_mode : mode_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (pop) begin
          state_d = ST_SHOW;
        end
      end
      ST_SHOW: begin
        if (pclk_fall) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      mode_q <= `MODE_TFT24;
      mode_seen_q <= 1'b0;
      data_q <= 24'h000000;
      shift_q <= 1'b1;
      line_q <= 1'b0;
      frame_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (!mode_seen_q) begin
        mode_q <= panel_mode;
        mode_seen_q <= 1'b1;
      end
      if (pop) begin
        if (head[`ENTRY_FRAME_BIT]) begin
          mode_q <= panel_mode;
        end
        data_q <= map_word(mode_use, head[`WORD_W-1:0]);
        // The panel latches on the rising shift edge in mid period.
        shift_q <= 1'b0;
        line_q <= head[`ENTRY_LINE_BIT];
        frame_q <= head[`ENTRY_FRAME_BIT];
      end else if (pclk_rise) begin
        line_q <= 1'b0;
        frame_q <= 1'b0;
      end
      if (state_q == ST_SHOW && pclk_fall) begin
        shift_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign panel_data_out = data_q;
  assign panel_shift_clock = shift_q;
  assign panel_line_clock = line_q;
  assign frame_start_pulse = frame_q;

endmodule

//--- tb/lcd_panel_data_mapper_chk.sv
// Port checks for the panel data mapper.
`timescale 1ns/10ps
`include "panel_map_map.vh"
module lcd_panel_data_mapper_chk (
  input logic clk,
  input logic reset_n,
  input logic [`MODE_W-1:0] panel_mode,
  input logic [`WORD_W-1:0] panel_data_out,
  input logic panel_shift_clock,
  input logic panel_line_clock,
  input logic frame_start_pulse
);
  wire [`MODE_W-1:0] m = panel_mode;
  wire [`WORD_W-1:0] d = panel_data_out;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_new;
    $fell(panel_shift_clock);
  endsequence
  property p_t18;
    s_new ##0 (m == `MODE_TFT18) |-> {d[17:16], d[9:8], d[1:0]} == 6'h00;
  endproperty
  property p_t12;
    s_new ##0 (m == `MODE_TFT12) |-> {d[19:16], d[11:8], d[3:0]} == 12'h000;
  endproperty
  property p_t9;
    s_new ##0 (m == `MODE_TFT9) |-> {d[20:16], d[12:8], d[4:0]} == 15'h0000;
  endproperty
  property p_s16;
    s_new ##0 (m == `MODE_STN16) |-> {d[17:16], d[9:8], d[3:0]} == 8'h00;
  endproperty
  property p_s8;
    s_new ##0 (m == `MODE_STN8 || m == `MODE_MONO) |-> {d[23:16], d[11:8], d[3:0]} == 16'h0000;
  endproperty
  property p_none;
    s_new ##0 (m == 3'h7) |-> d == 24'h000000;
  endproperty
  property p_shift;
    s_new |-> !panel_shift_clock [*2] ##[1:14] panel_shift_clock;
  endproperty
  property p_hold;
    !$fell(panel_shift_clock) |-> $stable(panel_data_out);
  endproperty
  property p_frame;
    $rose(frame_start_pulse) |-> (frame_start_pulse && !panel_shift_clock) ##1 frame_start_pulse [*7];
  endproperty
  property p_line;
    $rose(panel_line_clock) |-> panel_line_clock [*8];
  endproperty
  a_t18: assert property (p_t18) else $error("stray line in narrow mode");
  a_t12: assert property (p_t12) else $error("stray line in narrow mode");
  a_t9: assert property (p_t9) else $error("stray line in narrow mode");
  a_s16: assert property (p_s16) else $error("stray line in wide stn mode");
  a_s8: assert property (p_s8) else $error("stray line in narrow stn mode");
  a_none: assert property (p_none) else $error("data in unused mode");
  a_shift: assert property (p_shift) else $error("shift clock pulse wrong");
  a_hold: assert property (p_hold) else $error("data moved without shift");
  a_frame: assert property (p_frame) else $error("frame pulse wrong");
  a_line: assert property (p_line) else $error("line pulse too short");
endmodule
bind lcd_panel_data_mapper lcd_panel_data_mapper_chk u_chk (
  .clk(clk), .reset_n(reset_n), .panel_mode(panel_mode), .panel_data_out(panel_data_out),
  .panel_shift_clock(panel_shift_clock), .panel_line_clock(panel_line_clock),
  .frame_start_pulse(frame_start_pulse));

//--- tb/panel_model.sv
// Flat panel that clocks the pixel link and latches each shown word.
`timescale 1ns/10ps
module panel_model (
  input logic run,
  output logic pix_clk,
  input logic [23:0] panel_data_out,
  input logic panel_shift_clock,
  input logic panel_line_clock,
  input logic frame_start_pulse,
  output logic [25:0] last_word,
  output int count
);
  // The link clock stands low between bursts.
  initial begin
    pix_clk = 1'b0;
    count = 0;
    // Each period opens low and only rises if the burst is still on.
    // A stop request therefore never leaves a stray rise behind.
    forever begin
      wait (run);
      #24;
      if (run) begin
        pix_clk = 1'b1;
        #24 pix_clk = 1'b0;
      end
    end
  end
  always @(posedge panel_shift_clock) begin
    last_word <= {frame_start_pulse, panel_line_clock, panel_data_out};
    count <= count + 1;
  end
endmodule

//--- tb/tb_lcd_panel_data_mapper.sv
// Self-checking bench for the panel data mapper.
`timescale 1ns/10ps
`include "panel_map_map.vh"
module tb_lcd_panel_data_mapper;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [`MODE_W-1:0] panel_mode = `MODE_TFT24;
  logic in_valid = 1'b0;
  logic [`WORD_W-1:0] in_word = 24'h000000;
  logic in_line_end = 1'b0;
  logic in_frame_first = 1'b0;
  logic run = 1'b0;
  logic pix_clk, in_ready, shift, line, frame;
  logic [`WORD_W-1:0] pdo;
  logic [`ENTRY_W-1:0] last_word;
  int count;
  int err_total = 0;
  int num_checks = 0;
  lcd_panel_data_mapper u_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
    .panel_mode(panel_mode), .pix_clk(pix_clk), .in_valid(in_valid), .in_ready(in_ready),
    .in_word(in_word), .in_line_end(in_line_end), .in_frame_first(in_frame_first),
    .panel_data_out(pdo), .panel_shift_clock(shift), .panel_line_clock(line),
    .frame_start_pulse(frame));
  panel_model u_panel (.run(run), .pix_clk(pix_clk), .panel_data_out(pdo),
    .panel_shift_clock(shift), .panel_line_clock(line), .frame_start_pulse(frame),
    .last_word(last_word), .count(count));
  initial forever #2.5 clk = ~clk;
  function automatic logic [23:0] exp_map(input logic [2:0] m, input logic [23:0] w);
    logic [7:0] r, g, b;
    r = w[23:16];
    g = w[15:8];
    b = w[7:0];
    case (m)
      `MODE_TFT24: exp_map = w;
      `MODE_TFT18: exp_map = {r[7:2], 2'h0, g[7:2], 2'h0, b[7:2], 2'h0};
      `MODE_TFT12: exp_map = {r[7:4], 4'h0, g[7:4], 4'h0, b[7:4], 4'h0};
      `MODE_TFT9: exp_map = {r[7:5], 5'h00, g[7:5], 5'h00, b[7:5], 5'h00};
      `MODE_STN16: exp_map = {g[3:0], g[7:6], 2'h0, b[7:4], g[5:4], 2'h0, b[3:0], 4'h0};
      `MODE_STN8, `MODE_MONO: exp_map = {8'h00, g[3:0], 4'h0, b[3:0], 4'h0};
      default: exp_map = 24'h000000;
    endcase
  endfunction
  task automatic cmp(input logic [25:0] got, input logic [25:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [23:0] w, input logic le, input logic ff);
    int i;
    i = 0;
    @(negedge clk);
    in_valid = 1'b1;
    in_word = w;
    in_line_end = le;
    in_frame_first = ff;
    // Ready is a flop output, so it is judged at the falling edge where it is settled.
    while (in_ready !== 1'b1 && i < 400) begin
      @(negedge clk);
      i++;
    end
    if (i >= 400) begin
      err_total++;
      $display("mismatch at %0t: input never ready", $time);
    end
    @(posedge clk);
    @(negedge clk);
    in_valid = 1'b0;
  endtask
  task automatic get_word(input logic [25:0] exp);
    int n = count;
    int i = 0;
    while (count == n && i < 2000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 2000) begin
      err_total++;
      $display("mismatch at %0t: no word shown", $time);
    end
    #1;
    cmp(last_word, exp);
  endtask
  task automatic t_modes();
    logic [23:0] w;
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      panel_mode = k[3:1];
      w = k[0] ? 24'h5A3C1E : 24'hA5C3E1;
      send(w, !k[0], !k[0]);
      run = 1'b1;
      get_word({!k[0], !k[0], exp_map(k[3:1], w)});
      run = 1'b0;
    end
    $display("mode mapping test done");
  endtask
  task automatic t_burst();
    @(negedge clk);
    panel_mode = `MODE_TFT24;
    send(24'h111111, 1'b0, 1'b1);
    send(24'h222222, 1'b0, 1'b0);
    fork
      send(24'h333333, 1'b1, 1'b0);
      begin
        repeat (20) @(posedge clk);
        cmp({25'h0, in_ready}, 26'h0);
        run = 1'b1;
      end
    join
    get_word({2'h2, 24'h111111});
    get_word({2'h0, 24'h222222});
    get_word({2'h1, 24'h333333});
    run = 1'b0;
    $display("stalled burst test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (5) @(negedge clk);
    t_modes();
    t_burst();
    close_out();
  end
endmodule
